// [rbs_axi_slave.sv]
`timescale 1ns/10ps
module rbs_axi_slave (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   rbs_reg_if.slave rif
);
   logic aw_full_reg, aw_full_next;
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic w_full_reg, w_full_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic do_wr;

   assign awready = !aw_full_reg && !bvalid_reg;
   assign wready = !w_full_reg && !bvalid_reg;
   assign arready = !rvalid_reg;
   assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
   assign rif.wr_en = do_wr;
   assign rif.wr_addr = aw_addr_reg;
   assign rif.wr_data = w_data_reg;
   assign rif.wr_strb = w_strb_reg;
   assign rif.rd_en = arvalid && arready;
   assign rif.rd_addr = araddr;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   always_comb begin
      aw_full_next = aw_full_reg;
      aw_addr_next = aw_addr_reg;
      w_full_next = w_full_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (awvalid && awready) begin
         aw_full_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && wready) begin
         w_full_next = 1'b1;
         w_data_next = wdata;
         w_strb_next = wstrb;
      end
      if (do_wr) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = rif.wr_hit ? rbs_pkg::RESP_OKAY : rbs_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (rif.rd_en) begin
         rvalid_next = 1'b1;
         rdata_next = rif.rd_data;
         rresp_next = rif.rd_hit ? rbs_pkg::RESP_OKAY : rbs_pkg::RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
      end else begin
         aw_full_reg <= aw_full_next;
         aw_addr_reg <= aw_addr_next;
         w_full_reg <= w_full_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end
endmodule

// [rbs_pin_sampler.sv]
`timescale 1ns/10ps
module rbs_pin_sampler (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic start,
   input wire logic osc_div_tick,
   input wire logic pin_in,
   output logic drive,
   output logic pin_low_seen,
   output logic ext_reset
);
   rbs_pkg::rbs_pin_state_type state_reg, state_next;
   logic [4:0] hold_reg, hold_next;
   logic [5:0] tick_reg, tick_next;
   logic seen_reg, seen_next;
   logic ext_reg, ext_next;

   assign drive = (state_reg == rbs_pkg::RBS_PS_DRIVE);
   assign pin_low_seen = seen_reg;
   assign ext_reset = ext_reg;

   always_comb begin
      state_next = state_reg;
      hold_next = hold_reg;
      tick_next = tick_reg;
      seen_next = 1'b0;
      ext_next = 1'b0;
      unique case (state_reg)
         rbs_pkg::RBS_PS_IDLE: begin
            if (start) begin
               state_next = rbs_pkg::RBS_PS_DRIVE;
               hold_next = 5'h00;
            end else if (!pin_in) begin
               // Someone else pulls the pin: an external reset
               state_next = rbs_pkg::RBS_PS_EXT;
               ext_next = 1'b1;
            end
         end
         rbs_pkg::RBS_PS_DRIVE: begin
            if (hold_reg == rbs_pkg::PIN_HOLD_CYC - 5'h01) begin
               state_next = rbs_pkg::RBS_PS_COUNT;
               tick_next = 6'h00;
            end else begin
               hold_next = hold_reg + 5'h01;
            end
         end
         rbs_pkg::RBS_PS_COUNT: begin
            if (start) begin
               state_next = rbs_pkg::RBS_PS_DRIVE;
               hold_next = 5'h00;
            end else if (osc_div_tick) begin
               if (tick_reg == rbs_pkg::PIN_SAMPLE_TICKS - 6'h01) begin
                  // Pin still low after release: external party holds it
                  seen_next = !pin_in;
                  state_next = pin_in ? rbs_pkg::RBS_PS_IDLE : rbs_pkg::RBS_PS_EXT;
               end else begin
                  tick_next = tick_reg + 6'h01;
               end
            end
         end
         rbs_pkg::RBS_PS_EXT: begin
            if (start) begin
               state_next = rbs_pkg::RBS_PS_DRIVE;
               hold_next = 5'h00;
            end else if (pin_in) begin
               state_next = rbs_pkg::RBS_PS_IDLE;
            end
         end
      endcase
   end

   // Power-on starts by driving the pin, as any internal reset does
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= rbs_pkg::RBS_PS_DRIVE;
         hold_reg <= 5'h00;
         tick_reg <= 6'h00;
         seen_reg <= 1'b0;
         ext_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         hold_reg <= hold_next;
         tick_reg <= tick_next;
         seen_reg <= seen_next;
         ext_reg <= ext_next;
      end
   end

   chk_pin_sample_time: assert property (@(posedge mclk) disable iff (!nrst)
      (state_reg == rbs_pkg::RBS_PS_COUNT && osc_div_tick && !start
       && tick_reg == rbs_pkg::PIN_SAMPLE_TICKS - 6'h01 && !pin_in) |=> pin_low_seen)
      else $error("pin not flagged low at sample point");
endmodule

// [rbs_pkg.sv]
package rbs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_BRK_EXIT = 8'h00;
   localparam logic [7:0] OFF_RST_CAUSE = 8'h04;
   localparam logic [7:0] OFF_BRK_CTRL = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

   // break_exit_status field
   localparam int BIT_BRK_EXIT = 1;
   // break_flag_clear_control field
   localparam int BIT_BRK_CLR_EN = 7;
   // reset_cause_status fields
   localparam int BIT_RC_POR = 7;
   localparam int BIT_RC_PIN = 6;
   localparam int BIT_RC_WDOG = 5;
   localparam int BIT_RC_OPCODE = 4;
   localparam int BIT_RC_FETCH = 3;
   localparam int BIT_RC_USB = 2;
   localparam int BIT_RC_LOWV = 1;
   localparam logic [7:0] RC_RESET_VAL = 8'h80;
   localparam logic [7:0] RC_PIN_ONLY = 8'h40;
   // Interrupt status fields
   localparam int IRQ_W = 2;
   localparam int BIT_IRQ_BRK = 0;
   localparam int BIT_IRQ_PIN = 1;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Reset pin timing
   localparam logic [4:0] PIN_HOLD_CYC = 5'h10;
   localparam logic [5:0] PIN_SAMPLE_TICKS = 6'h20;

   typedef enum logic [1:0] {
      RBS_PS_IDLE = 2'b00,
      RBS_PS_DRIVE = 2'b01,
      RBS_PS_COUNT = 2'b10,
      RBS_PS_EXT = 2'b11
   } rbs_pin_state_type;
endpackage

// [rbs_reg_if.sv]
`timescale 1ns/10ps
interface rbs_reg_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_hit;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_hit;
   modport slave(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_hit, rd_data, rd_hit);
   modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface

// [rbs_top.sv]
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// Operation
// - Break exiting stop or wait sets flag
// - Writing zero or reset clears break-exit flag
// - Reading reset-cause register clears all flags
// - Power-up leaves only power-on flag set
// - Drive pin low, sample 32 ticks later
// - Power-on flag set by power-on reset
// - External pin flag from pin reset
// - Watchdog flag from watchdog expiry
// - Illegal-instruction flag from illegal opcode
// - Illegal-address flag only on opcode fetch
// - USB flag from USB reset request
// - Low-voltage flag from low-voltage reset
// - In break, clears need the enable
module rbs_top (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic in_break,
   input wire logic break_exit_stop_wait,
   input wire logic rst_watchdog,
   input wire logic rst_illegal_opcode,
   input wire logic rst_illegal_addr,
   input wire logic illegal_addr_is_fetch,
   input wire logic rst_usb,
   input wire logic rst_low_voltage,
   input wire logic osc_div_tick,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe_n,
   output logic sys_reset_n,
   output logic irq
);
   rbs_reg_if rif();

   logic brk_exit_reg;
   logic brk_exit_next;
   logic [7:0] rcause_reg;
   logic [7:0] rcause_next;
   logic clr_en_reg;
   logic clr_en_next;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_stat_next;
   logic [1:0] irq_mask_reg;
   logic [1:0] irq_mask_next;
   logic [31:0] rd_mux;
   logic [7:0] int_causes;
   logic int_reset;
   logic clear_ok;
   logic lane0;
   logic wr_brk;
   logic wr_rc;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic [4:0] cause_pins;
   logic rd_rc;
   logic pin_drive;
   logic pin_low_seen;
   logic ext_reset;

   rbs_axi_slave u_axi (
      .mclk(mclk),
      .nrst(nrst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rif(rif)
   );

   rbs_pin_sampler u_pin (
      .mclk(mclk),
      .nrst(nrst),
      .start(int_reset),
      .osc_div_tick(osc_div_tick),
      .pin_in(rst_pin_in),
      .drive(pin_drive),
      .pin_low_seen(pin_low_seen),
      .ext_reset(ext_reset)
   );

   // Open-drain: only ever pulls low
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe_n = !pin_drive;
   assign sys_reset_n = !pin_drive;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Data accesses to a bad address are not a reset cause
   always_comb begin
      int_causes = 8'h00;
      int_causes[rbs_pkg::BIT_RC_WDOG] = rst_watchdog;
      int_causes[rbs_pkg::BIT_RC_OPCODE] = rst_illegal_opcode;
      int_causes[rbs_pkg::BIT_RC_FETCH] = rst_illegal_addr && illegal_addr_is_fetch;
      int_causes[rbs_pkg::BIT_RC_USB] = rst_usb;
      int_causes[rbs_pkg::BIT_RC_LOWV] = rst_low_voltage;
   end
   assign int_reset = |int_causes;
   // Raw cause inputs, so checks see single-cause resets
   assign cause_pins = {rst_watchdog, rst_illegal_opcode, rst_illegal_addr,
      rst_usb, rst_low_voltage};

   // Debug reads in break must not destroy state unless allowed
   assign clear_ok = !in_break || clr_en_reg;
   assign lane0 = rif.wr_strb[0];
   assign wr_brk = rif.wr_en && rif.wr_addr == rbs_pkg::OFF_BRK_EXIT;
   assign wr_rc = rif.wr_en && rif.wr_addr == rbs_pkg::OFF_RST_CAUSE;
   assign wr_ctrl = rif.wr_en && rif.wr_addr == rbs_pkg::OFF_BRK_CTRL;
   assign wr_stat = rif.wr_en && rif.wr_addr == rbs_pkg::OFF_IRQ_STAT;
   assign wr_mask = rif.wr_en && rif.wr_addr == rbs_pkg::OFF_IRQ_MASK;
   assign rd_rc = rif.rd_en && rif.rd_addr == rbs_pkg::OFF_RST_CAUSE;
   assign rif.wr_hit = wr_brk || wr_rc || wr_ctrl || wr_stat || wr_mask;

   always_comb begin
      rd_mux = 32'h0000_0000;
      rif.rd_hit = 1'b1;
      unique case (rif.rd_addr)
         rbs_pkg::OFF_BRK_EXIT: rd_mux[rbs_pkg::BIT_BRK_EXIT] = brk_exit_reg;
         rbs_pkg::OFF_RST_CAUSE: rd_mux[7:0] = rcause_reg;
         rbs_pkg::OFF_BRK_CTRL: rd_mux[rbs_pkg::BIT_BRK_CLR_EN] = clr_en_reg;
         rbs_pkg::OFF_IRQ_STAT: rd_mux[1:0] = irq_stat_reg;
         rbs_pkg::OFF_IRQ_MASK: rd_mux[1:0] = irq_mask_reg;
         default: rif.rd_hit = 1'b0;
      endcase
   end
   assign rif.rd_data = rd_mux;

   // Flags: a new event in the clearing cycle wins
   always_comb begin
      brk_exit_next = brk_exit_reg;
      if (wr_brk && lane0 && !rif.wr_data[rbs_pkg::BIT_BRK_EXIT] && clear_ok) begin
         brk_exit_next = 1'b0;
      end
      if (break_exit_stop_wait) begin
         brk_exit_next = 1'b1;
      end
   end

   always_comb begin
      rcause_next = rcause_reg;
      if (rd_rc && clear_ok) begin
         rcause_next = 8'h00;
      end
      if (ext_reset) begin
         rcause_next = rbs_pkg::RC_PIN_ONLY;
      end
      if (int_reset) begin
         // Only the latest reset is reported
         rcause_next = int_causes;
      end
      if (pin_low_seen) begin
         rcause_next[rbs_pkg::BIT_RC_PIN] = 1'b1;
      end
   end

   always_comb begin
      clr_en_next = clr_en_reg;
      if (wr_ctrl && lane0) begin
         clr_en_next = rif.wr_data[rbs_pkg::BIT_BRK_CLR_EN];
      end
   end

   always_comb begin
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (wr_stat && lane0 && clear_ok) begin
         irq_stat_next = irq_stat_reg & ~rif.wr_data[1:0];
      end
      if (break_exit_stop_wait) begin
         irq_stat_next[rbs_pkg::BIT_IRQ_BRK] = 1'b1;
      end
      if (pin_low_seen || ext_reset) begin
         irq_stat_next[rbs_pkg::BIT_IRQ_PIN] = 1'b1;
      end
      if (wr_mask && lane0) begin
         irq_mask_next = rif.wr_data[1:0];
      end
   end

   // nrst is the power-on reset; internal resets do not reach here
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         brk_exit_reg <= 1'b0;
         rcause_reg <= rbs_pkg::RC_RESET_VAL;
         clr_en_reg <= 1'b0;
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= rbs_pkg::IRQ_MASK_RESET;
      end else begin
         brk_exit_reg <= brk_exit_next;
         rcause_reg <= rcause_next;
         clr_en_reg <= clr_en_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   logic first_cyc_reg;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         first_cyc_reg <= 1'b1;
      end else begin
         first_cyc_reg <= 1'b0;
      end
   end

   chk_por_init_value: assert property (@(posedge mclk) disable iff (!nrst)
      first_cyc_reg |-> rcause_reg == rbs_pkg::RC_RESET_VAL)
      else $error("reset cause not power-on only after reset");

   chk_brk_exit_set: assert property (@(posedge mclk) disable iff (!nrst)
      break_exit_stop_wait |=> brk_exit_reg)
      else $error("break exit did not set flag");

   chk_brk_exit_clear: assert property (@(posedge mclk) disable iff (!nrst)
      (wr_brk && lane0 && !rif.wr_data[rbs_pkg::BIT_BRK_EXIT] && clear_ok
       && !break_exit_stop_wait) |=> !brk_exit_reg && bvalid)
      else $error("break exit flag not cleared by write");

   chk_rc_read_clear: assert property (@(posedge mclk) disable iff (!nrst)
      (rd_rc && clear_ok && !int_reset && !ext_reset && !pin_low_seen)
      |=> rcause_reg == 8'h00 && rvalid)
      else $error("reset cause not cleared by read");

   chk_por_read_clear: assert property (@(posedge mclk) disable iff (!nrst)
      (rd_rc && clear_ok && rcause_reg[rbs_pkg::BIT_RC_POR] && !int_reset)
      |=> !rcause_reg[rbs_pkg::BIT_RC_POR])
      else $error("power-on flag not cleared by read");

   chk_break_hold: assert property (@(posedge mclk) disable iff (!nrst)
      (rd_rc && in_break && !clr_en_reg && !int_reset && !ext_reset && !pin_low_seen)
      |=> $stable(rcause_reg))
      else $error("reset cause cleared in break without enable");

   chk_stat_break_hold: assert property (@(posedge mclk) disable iff (!nrst)
      (wr_stat && in_break && !clr_en_reg && !break_exit_stop_wait && !pin_low_seen
       && !ext_reset) |=> $stable(irq_stat_reg))
      else $error("interrupt status cleared in break without enable");

   chk_clear_en_set: assert property (@(posedge mclk) disable iff (!nrst)
      (wr_ctrl && lane0 && rif.wr_data[rbs_pkg::BIT_BRK_CLR_EN]) |=> clr_en_reg)
      else $error("break clear enable not set by write");

   chk_wdog_cause: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_watchdog && $onehot(cause_pins) && !pin_low_seen)
      |=> (rcause_reg[rbs_pkg::BIT_RC_WDOG] && $onehot(rcause_reg)) ##1 !rst_pin_oe_n)
      else $error("watchdog reset not recorded");

   chk_opcode_cause: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_illegal_opcode && $onehot(cause_pins) && !pin_low_seen)
      |=> rcause_reg[rbs_pkg::BIT_RC_OPCODE] && $onehot(rcause_reg))
      else $error("illegal opcode reset not recorded");

   chk_fetch_cause: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_illegal_addr && illegal_addr_is_fetch && $onehot(cause_pins) && !pin_low_seen)
      |=> rcause_reg[rbs_pkg::BIT_RC_FETCH] && $onehot(rcause_reg))
      else $error("illegal fetch reset not recorded");

   chk_usb_cause: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_usb && $onehot(cause_pins) && !pin_low_seen)
      |=> rcause_reg[rbs_pkg::BIT_RC_USB] && $onehot(rcause_reg))
      else $error("usb reset not recorded");

   chk_lowv_cause: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_low_voltage && $onehot(cause_pins) && !pin_low_seen)
      |=> rcause_reg[rbs_pkg::BIT_RC_LOWV] && $onehot(rcause_reg))
      else $error("low voltage reset not recorded");

   chk_data_addr_ignored: assert property (@(posedge mclk) disable iff (!nrst)
      (rst_illegal_addr && !illegal_addr_is_fetch && !rcause_reg[rbs_pkg::BIT_RC_FETCH])
      |=> !rcause_reg[rbs_pkg::BIT_RC_FETCH])
      else $error("data access set illegal address cause");

   chk_pin_added: assert property (@(posedge mclk) disable iff (!nrst)
      (pin_low_seen && !int_reset) |=> rcause_reg[rbs_pkg::BIT_RC_PIN])
      else $error("pin held low after reset not recorded");

   chk_ext_pin_cause: assert property (@(posedge mclk) disable iff (!nrst)
      (ext_reset && !int_reset) |=> rcause_reg == rbs_pkg::RC_PIN_ONLY)
      else $error("external pin reset not recorded");

   chk_irq_level: assert property (@(posedge mclk) disable iff (!nrst)
      (break_exit_stop_wait && irq_mask_reg[rbs_pkg::BIT_IRQ_BRK] && !wr_mask) |=> irq)
      else $error("unmasked break event gave no interrupt");
endmodule

// [rbs_top_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module rbs_top_tb;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic in_break = 1'b0;
   logic [5:0] pulse_v = 6'h00;
   logic fetch = 1'b0;
   logic tick = 1'b0;
   logic ext_low = 1'b0;
   logic pin_lvl;
   logic rst_pin_out;
   logic rst_pin_oe_n;
   logic sys_reset_n;
   logic irq;
   int fail_count = 0;
   int n_tests = 0;
   typedef struct packed {
      logic [5:0] p;
      logic f;
      logic [7:0] e;
   } rbs_row_type;
   // Pulse bits: break exit, watchdog, opcode, address, usb, low voltage
   rbs_row_type rows [6] = '{'{6'h10, 1'b0, 8'h20}, '{6'h08, 1'b0, 8'h10},
      '{6'h04, 1'b1, 8'h08}, '{6'h02, 1'b0, 8'h04}, '{6'h01, 1'b0, 8'h02},
      '{6'h04, 1'b0, 8'h00}};

   // Pull-up on the reset pin unless someone pulls it low
   assign pin_lvl = rst_pin_oe_n ? ~ext_low : rst_pin_out;

   always #2 mclk = ~mclk;

   always @(posedge mclk) begin
      tick <= ~tick;
   end

   rbs_top rbs_top_inst (.mclk(mclk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .in_break(in_break), .break_exit_stop_wait(pulse_v[5]), .rst_watchdog(pulse_v[4]),
      .rst_illegal_opcode(pulse_v[3]), .rst_illegal_addr(pulse_v[2]),
      .illegal_addr_is_fetch(fetch), .rst_usb(pulse_v[1]), .rst_low_voltage(pulse_v[0]),
      .osc_div_tick(tick), .rst_pin_in(pin_lvl), .rst_pin_out(rst_pin_out),
      .rst_pin_oe_n(rst_pin_oe_n), .sys_reset_n(sys_reset_n), .irq(irq));

   task automatic results();
      if (fail_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Both tasks are entered just after a rising edge and leave just after one
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int t;
      logic ta, tw, ha, hw;
      t = 0;
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw) && t < 100) begin
         @(negedge mclk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         @(posedge mclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         ta = ta || ha;
         tw = tw || hw;
         t++;
      end
      @(negedge mclk);
      while (bvalid !== 1'b1 && t < 100) begin
         @(negedge mclk);
         t++;
      end
      `CHK("bvalid", 1'b1, bvalid)
      `CHK("bresp", er, bresp)
      @(posedge mclk);
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int t;
      t = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge mclk);
      while (arready !== 1'b1 && t < 100) begin
         @(negedge mclk);
         t++;
      end
      @(posedge mclk);
      arvalid <= 1'b0;
      @(negedge mclk);
      while (rvalid !== 1'b1 && t < 100) begin
         @(negedge mclk);
         t++;
      end
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rresp", er, rresp)
      `CHK("rdata", {24'h000000, e}, rdata)
      @(posedge mclk);
   endtask

   task automatic chk_irq(input logic e);
      @(negedge mclk);
      `CHK("irq", e, irq)
      @(posedge mclk);
   endtask

   task automatic pulse(input logic [5:0] v);
      pulse_v <= v;
      @(posedge mclk);
      pulse_v <= 6'h00;
   endtask

   // Long settle covers the pin hold and the 32-tick sample delay
   task automatic do_reset();
      nrst <= 1'b0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      repeat (150) @(posedge mclk);
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      results();
   end

   initial begin
      int i;
      int cnt;
      @(posedge mclk);
      do_reset();
      wr(rbs_pkg::OFF_RST_CAUSE, 8'hff, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, rbs_pkg::RC_RESET_VAL, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_CTRL, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_IRQ_MASK, 8'h00, rbs_pkg::RESP_OKAY);
      for (i = 0; i < 6; i++) begin
         fetch <= rows[i].f;
         pulse(rows[i].p);
         cnt = 0;
         repeat (150) begin
            @(negedge mclk);
            if (rst_pin_oe_n === 1'b0 && sys_reset_n === 1'b0 && rst_pin_out === 1'b0) cnt++;
         end
         `CHK("pin drive cycles", (rows[i].e != 0) ? int'(rbs_pkg::PIN_HOLD_CYC) : 0, cnt)
         @(posedge mclk);
         chk_rd(rbs_pkg::OFF_RST_CAUSE, rows[i].e, rbs_pkg::RESP_OKAY);
         chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h00, rbs_pkg::RESP_OKAY);
      end
      fetch <= 1'b0;
      ext_low <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_low <= 1'b0;
      repeat (150) @(posedge mclk);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, rbs_pkg::RC_PIN_ONLY, rbs_pkg::RESP_OKAY);
      // Pin held low past the sample point adds the pin cause
      ext_low <= 1'b1;
      pulse(6'h10);
      repeat (150) @(posedge mclk);
      ext_low <= 1'b0;
      chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h60, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_IRQ_STAT, 8'h02, rbs_pkg::RESP_OKAY);
      wr(rbs_pkg::OFF_IRQ_STAT, 8'h02, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_IRQ_STAT, 8'h00, rbs_pkg::RESP_OKAY);
      pulse(6'h20);
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h02, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_IRQ_STAT, 8'h01, rbs_pkg::RESP_OKAY);
      chk_irq(1'b0);
      wr(rbs_pkg::OFF_IRQ_MASK, 8'h01, rbs_pkg::RESP_OKAY);
      chk_irq(1'b1);
      wr(rbs_pkg::OFF_IRQ_STAT, 8'h01, rbs_pkg::RESP_OKAY);
      chk_irq(1'b0);
      wr(rbs_pkg::OFF_BRK_EXIT, 8'h02, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h02, rbs_pkg::RESP_OKAY);
      wr(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      // In break with the enable off, every kind of clear must be ignored
      in_break <= 1'b1;
      pulse(6'h01);
      repeat (150) @(posedge mclk);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h02, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h02, rbs_pkg::RESP_OKAY);
      wr(rbs_pkg::OFF_IRQ_MASK, 8'h01, rbs_pkg::RESP_OKAY);
      pulse(6'h20);
      wr(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h02, rbs_pkg::RESP_OKAY);
      wr(rbs_pkg::OFF_IRQ_STAT, 8'h01, rbs_pkg::RESP_OKAY);
      chk_irq(1'b1);
      wr(rbs_pkg::OFF_BRK_CTRL, 8'h80, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_CTRL, 8'h80, rbs_pkg::RESP_OKAY);
      wr(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h02, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, 8'h00, rbs_pkg::RESP_OKAY);
      wr(rbs_pkg::OFF_IRQ_STAT, 8'h01, rbs_pkg::RESP_OKAY);
      chk_irq(1'b0);
      in_break <= 1'b0;
      wr(rbs_pkg::OFF_BRK_CTRL, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(8'h14, 8'h00, rbs_pkg::RESP_SLVERR);
      wr(8'h14, 8'hff, rbs_pkg::RESP_SLVERR);
      // Second reset with the flag set
      pulse(6'h20);
      do_reset();
      chk_rd(rbs_pkg::OFF_BRK_EXIT, 8'h00, rbs_pkg::RESP_OKAY);
      chk_rd(rbs_pkg::OFF_RST_CAUSE, rbs_pkg::RC_RESET_VAL, rbs_pkg::RESP_OKAY);
      results();
   end
endmodule
